// File: verilog/tpc_regs.sv
// Run-time control register bank and frame-start sequencer for a test pattern generator.
// Assumes a same-clock software port and a same-clock downstream packet consumer and pattern engine.
`timescale 1ns/10ps

// Overview of operation
// [RL1] Sixteen-bit registers selected by word address
// [RL2] Snapshot all controls once per frame start
// [RL3] Live writes never disturb the running frame
// [RL4] Control packet precedes each image data packet
// [RL5] Interlaced: sample once, packet every field
// [RL6] Run enable low halts before next sampling
// [RL7] Run enable resets per run-time control option
// [RL8] Border bit one, resets off, others unused
// [RL9] Busy status high during frame, low between
// [RL10] Software keeps width and height in range
// [RL11] Scan code: progressive, even first, odd first
// [RL12] Pattern index value selects configuration directly
// [RL13] Three uniform plane values at eight to ten
// [RL14] Reduced readback hides written values
// [RL15] Unused locations ignore writes, read zero
module tpc_regs #(
	parameter bit RUNTIME_CTRL = 1'b1,
	parameter bit REDUCED_READBACK = 1'b0,
	parameter logic [15:0] MAX_WIDTH = tpc_pkg::RESET_WIDTH,
	parameter logic [15:0] MAX_HEIGHT = tpc_pkg::RESET_HEIGHT,
	parameter logic [15:0] DEFAULT_SCAN = tpc_pkg::RESET_SCAN,
	parameter logic DEFAULT_BORDER = tpc_pkg::RESET_BORDER,
	parameter logic [15:0] DEFAULT_PLANE0 = tpc_pkg::RESET_PLANE,
	parameter logic [15:0] DEFAULT_PLANE1 = tpc_pkg::RESET_PLANE,
	parameter logic [15:0] DEFAULT_PLANE2 = tpc_pkg::RESET_PLANE
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Register port
	input wire logic [tpc_pkg::ADDR_W-1:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [tpc_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_rd,
	output logic [tpc_pkg::DATA_W-1:0] reg_rdata,
	output logic reg_rvalid,
	// Control packet to downstream
	output logic pkt_valid,
	input wire logic pkt_ready,
	output logic [15:0] pkt_width,
	output logic [15:0] pkt_height,
	output logic [1:0] pkt_field,
	// Image data packet handshake with the pattern engine
	output logic img_active,
	input wire logic img_done,
	// Frame settings held for the pattern engine
	output logic [15:0] cur_pattern_index,
	output logic cur_border,
	output logic [15:0] cur_plane0,
	output logic [15:0] cur_plane1,
	output logic [15:0] cur_plane2
);

	localparam logic RESET_RUN = !RUNTIME_CTRL;
	localparam logic [tpc_pkg::SNAP_W-1:0] SNAP_INIT = {DEFAULT_BORDER, tpc_pkg::RESET_PATTERN,
		DEFAULT_PLANE0, DEFAULT_PLANE1, DEFAULT_PLANE2, MAX_WIDTH, MAX_HEIGHT};

	// Live register values
	logic run_enable_reg;
	logic border_reg;
	logic [15:0] frame_width_reg;
	logic [15:0] frame_height_reg;
	logic [15:0] scan_type_reg;
	logic [15:0] pattern_index_reg;
	logic [15:0] uniform_plane0_reg;
	logic [15:0] uniform_plane1_reg;
	logic [15:0] uniform_plane2_reg;

	// Sequencer state
	tpc_pkg::tpc_state_e state_reg;
	logic second_field_reg;
	logic interlaced_reg;
	logic odd_first_reg;
	logic busy_reg;
	logic [15:0] rdata_next;

	logic sample_now;
	logic wr_ok;
	logic [tpc_pkg::SNAP_W-1:0] snap_q;

	// Scan codes other than the two interlaced ones are treated as progressive
	function automatic logic scan_is_interlaced(input logic [15:0] code);
		scan_is_interlaced = (code[1:0] == tpc_pkg::SCAN_EVEN_FIRST || code[1:0] == tpc_pkg::SCAN_ODD_FIRST)
			&& (code[15:2] == 14'h0000);
	endfunction

	// Without run-time control the bank is fixed at its defaults
	assign wr_ok = reg_wr && RUNTIME_CTRL;
	// Sampling happens only in the gap and only while running
	assign sample_now = (state_reg == tpc_pkg::TPC_GAP) && run_enable_reg; // [RL6]

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			run_enable_reg <= RESET_RUN; // [RL7]
			border_reg <= DEFAULT_BORDER; // [RL8]
		end else if (wr_ok && reg_addr == tpc_pkg::ADDR_RUN_CONTROL) begin
			run_enable_reg <= reg_wdata[tpc_pkg::RUN_ENABLE_BIT]; // [RL6]
			border_reg <= reg_wdata[tpc_pkg::BORDER_BIT]; // [RL8]
		end
	end

	// Writes land in the live set at any time; the frame uses the snapshot
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			frame_width_reg <= MAX_WIDTH;
			frame_height_reg <= MAX_HEIGHT;
			scan_type_reg <= DEFAULT_SCAN;
			pattern_index_reg <= tpc_pkg::RESET_PATTERN;
			uniform_plane0_reg <= DEFAULT_PLANE0;
			uniform_plane1_reg <= DEFAULT_PLANE1;
			uniform_plane2_reg <= DEFAULT_PLANE2;
		end else if (wr_ok) begin // [RL3]
			unique case (reg_addr)
				tpc_pkg::ADDR_FRAME_WIDTH: begin
					frame_width_reg <= reg_wdata; // [RL1]
				end
				tpc_pkg::ADDR_FRAME_HEIGHT: begin
					frame_height_reg <= reg_wdata;
				end
				tpc_pkg::ADDR_SCAN_TYPE: begin
					scan_type_reg <= reg_wdata; // [RL11]
				end
				tpc_pkg::ADDR_PATTERN_INDEX: begin
					pattern_index_reg <= reg_wdata; // [RL12]
				end
				tpc_pkg::ADDR_UNIFORM_PLANE0: begin
					uniform_plane0_reg <= reg_wdata; // [RL13]
				end
				tpc_pkg::ADDR_UNIFORM_PLANE1: begin
					uniform_plane1_reg <= reg_wdata; // [RL13]
				end
				tpc_pkg::ADDR_UNIFORM_PLANE2: begin
					uniform_plane2_reg <= reg_wdata; // [RL13]
				end
				default: begin
					// Unused, reserved and unmapped words take no write
				end // [RL15]
			endcase
		end
	end

	// Whole control set captured in one edge at frame start
	tpc_snapshot #(
		.W(tpc_pkg::SNAP_W),
		.INIT(SNAP_INIT)
	) u_snapshot (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.load(sample_now), // [RL2]
		.d({border_reg, pattern_index_reg, uniform_plane0_reg, uniform_plane1_reg, uniform_plane2_reg,
			frame_width_reg, frame_height_reg}),
		.q(snap_q)
	);

	assign cur_border = snap_q[tpc_pkg::SNAP_W-1];
	assign cur_pattern_index = snap_q[95:80];
	assign cur_plane0 = snap_q[79:64];
	assign cur_plane1 = snap_q[63:48];
	assign cur_plane2 = snap_q[47:32];

	// Frame sequencer
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_reg <= tpc_pkg::TPC_GAP;
			second_field_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				tpc_pkg::TPC_GAP: begin
					if (sample_now) begin
						state_reg <= tpc_pkg::TPC_CTRL; // [RL4]
						second_field_reg <= 1'b0;
					end
				end
				tpc_pkg::TPC_CTRL: begin
					if (pkt_ready) begin
						state_reg <= tpc_pkg::TPC_DATA;
					end
				end
				tpc_pkg::TPC_DATA: begin
					if (img_done) begin
						if (interlaced_reg && !second_field_reg) begin
							// Second field gets its own packet but no new sample
							state_reg <= tpc_pkg::TPC_CTRL; // [RL5]
							second_field_reg <= 1'b1;
						end else begin
							state_reg <= tpc_pkg::TPC_GAP;
						end
					end
				end
				default: begin
					state_reg <= tpc_pkg::TPC_GAP;
				end
			endcase
		end
	end

	// Scan settings for this frame, fixed at sampling
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			interlaced_reg <= 1'b0;
			odd_first_reg <= 1'b0;
		end else if (sample_now) begin
			interlaced_reg <= scan_is_interlaced(scan_type_reg); // [RL11]
			odd_first_reg <= scan_type_reg[1:0] == tpc_pkg::SCAN_ODD_FIRST;
		end
	end

	// Control packet contents, loaded at sampling; the second field packet reloads only the field kind
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pkt_valid <= 1'b0;
			pkt_width <= MAX_WIDTH;
			pkt_height <= MAX_HEIGHT;
			pkt_field <= tpc_pkg::FIELD_PROGRESSIVE;
		end else if (sample_now) begin
			pkt_valid <= 1'b1; // [RL4]
			pkt_width <= frame_width_reg;
			// A field carries half the progressive height
			pkt_height <= scan_is_interlaced(scan_type_reg) ? {1'b0, frame_height_reg[15:1]} : frame_height_reg;
			if (!scan_is_interlaced(scan_type_reg)) begin
				pkt_field <= tpc_pkg::FIELD_PROGRESSIVE;
			end else if (scan_type_reg[1:0] == tpc_pkg::SCAN_ODD_FIRST) begin
				pkt_field <= tpc_pkg::FIELD_ODD;
			end else begin
				pkt_field <= tpc_pkg::FIELD_EVEN;
			end
		end else if (state_reg == tpc_pkg::TPC_DATA && img_done && interlaced_reg && !second_field_reg) begin
			pkt_valid <= 1'b1; // [RL5]
			pkt_field <= odd_first_reg ? tpc_pkg::FIELD_EVEN : tpc_pkg::FIELD_ODD;
		end else if (state_reg == tpc_pkg::TPC_CTRL && pkt_ready) begin
			pkt_valid <= 1'b0;
		end
	end

	// Image packet window and busy flag
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			img_active <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			if (state_reg == tpc_pkg::TPC_CTRL && pkt_ready) begin
				img_active <= 1'b1;
			end else if (state_reg == tpc_pkg::TPC_DATA && img_done) begin
				img_active <= 1'b0;
			end
			if (sample_now) begin
				busy_reg <= 1'b1; // [RL9]
			end else if (state_reg == tpc_pkg::TPC_DATA && img_done && !(interlaced_reg && !second_field_reg)) begin
				busy_reg <= 1'b0; // [RL9]
			end
		end
	end

	// Read mux; reduced readback still reports the busy flag
	always_comb begin
		rdata_next = 16'h0000;
		unique case (reg_addr)
			tpc_pkg::ADDR_RUN_STATE: begin
				rdata_next[tpc_pkg::BUSY_BIT] = busy_reg; // [RL9]
			end
			tpc_pkg::ADDR_RUN_CONTROL: begin
				rdata_next[tpc_pkg::RUN_ENABLE_BIT] = run_enable_reg;
				rdata_next[tpc_pkg::BORDER_BIT] = border_reg;
			end
			tpc_pkg::ADDR_FRAME_WIDTH: begin
				rdata_next = frame_width_reg;
			end
			tpc_pkg::ADDR_FRAME_HEIGHT: begin
				rdata_next = frame_height_reg;
			end
			tpc_pkg::ADDR_SCAN_TYPE: begin
				rdata_next = scan_type_reg;
			end
			tpc_pkg::ADDR_PATTERN_INDEX: begin
				rdata_next = pattern_index_reg;
			end
			tpc_pkg::ADDR_UNIFORM_PLANE0: begin
				rdata_next = uniform_plane0_reg;
			end
			tpc_pkg::ADDR_UNIFORM_PLANE1: begin
				rdata_next = uniform_plane1_reg;
			end
			tpc_pkg::ADDR_UNIFORM_PLANE2: begin
				rdata_next = uniform_plane2_reg;
			end
			default: begin
				rdata_next = 16'h0000; // [RL15]
			end
		endcase
		if (REDUCED_READBACK && reg_addr != tpc_pkg::ADDR_RUN_STATE) begin
			rdata_next = 16'h0000; // [RL14]
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			reg_rdata <= 16'h0000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= rdata_next; // [RL14]
			end
		end
	end

endmodule // tpc_regs

// File: verilog/tpc_pkg.sv
// Constants shared by the test pattern control register bank.
// Assumes a single clock domain and 16-bit word-addressed registers.
package tpc_pkg;

	localparam int DATA_W = 16;
	localparam int ADDR_W = 4;

	// Word addresses
	localparam logic [3:0] ADDR_RUN_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_RUN_STATE = 4'h1;
	localparam logic [3:0] ADDR_IRQ_UNUSED = 4'h2;
	localparam logic [3:0] ADDR_RESERVED = 4'h3;
	localparam logic [3:0] ADDR_FRAME_WIDTH = 4'h4;
	localparam logic [3:0] ADDR_FRAME_HEIGHT = 4'h5;
	localparam logic [3:0] ADDR_SCAN_TYPE = 4'h6;
	localparam logic [3:0] ADDR_PATTERN_INDEX = 4'h7;
	localparam logic [3:0] ADDR_UNIFORM_PLANE0 = 4'h8;
	localparam logic [3:0] ADDR_UNIFORM_PLANE1 = 4'h9;
	localparam logic [3:0] ADDR_UNIFORM_PLANE2 = 4'hA;

	// Field positions
	localparam int RUN_ENABLE_BIT = 0;
	localparam int BORDER_BIT = 1;
	localparam int BUSY_BIT = 0;

	// Scan type codes
	localparam logic [1:0] SCAN_PROGRESSIVE = 2'h0;
	localparam logic [1:0] SCAN_EVEN_FIRST = 2'h1;
	localparam logic [1:0] SCAN_ODD_FIRST = 2'h2;

	// Field kind carried by each control packet
	localparam logic [1:0] FIELD_PROGRESSIVE = 2'h0;
	localparam logic [1:0] FIELD_EVEN = 2'h1;
	localparam logic [1:0] FIELD_ODD = 2'h2;

	// Reset values
	localparam logic [15:0] RESET_WIDTH = 16'h0780;
	localparam logic [15:0] RESET_HEIGHT = 16'h0438;
	localparam logic [15:0] RESET_SCAN = 16'h0000;
	localparam logic [15:0] RESET_PATTERN = 16'h0000;
	localparam logic [15:0] RESET_PLANE = 16'h0010;
	localparam logic RESET_BORDER = 1'b0;

	// Width of the frame snapshot word
	localparam int SNAP_W = 6 * DATA_W + 1;

	typedef enum logic [1:0] {
		TPC_GAP = 2'b00,
		TPC_CTRL = 2'b01,
		TPC_DATA = 2'b10
	} tpc_state_e;

endpackage

// File: verilog/tpc_snapshot.sv
// Holds the per-frame copy of the control registers.
// Assumes load is a one-cycle strobe from the frame sequencer.
`timescale 1ns/10ps
module tpc_snapshot #(
	parameter int W = 8,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Capture
	input wire logic load,
	input wire logic [W-1:0] d,
	// Held copy
	output logic [W-1:0] q
);

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			q <= INIT;
		end else if (load) begin
			q <= d;
		end
	end

endmodule // tpc_snapshot

// File: test/tpc_sink_model.sv
// Downstream consumer of control packets and pattern engine stand-in.
// Assumes the block's clock; answers on the falling edge.
`timescale 1ns/10ps
module tpc_sink_model (
	// Clock
	input wire logic mclk,
	// Block status
	input wire logic pkt_valid,
	input wire logic img_active,
	// Extra wait cycles, zero answers at once
	input wire logic [3:0] lag,
	// Answers
	output logic pkt_ready,
	output logic img_done
);
	int cnt = 0;
	initial begin
		pkt_ready = 1'b0;
		img_done = 1'b0;
	end
	// Count runs on through the image so a slow packet also means a short image
	always @(negedge mclk) begin
		if (pkt_valid || img_active)
			cnt = cnt + 1;
		else
			cnt = 0;
		pkt_ready <= pkt_valid && cnt > lag;
		img_done <= img_active && !img_done && cnt > lag + 2;
	end
endmodule // tpc_sink_model

// File: test/tpc_regs_monitor.sv
// Port checker for the test pattern register bank.
// Bound into every tpc_regs; one clock domain.
`timescale 1ns/10ps
module tpc_regs_monitor (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid,
	// Packet side
	input wire logic pkt_valid,
	input wire logic pkt_ready,
	input wire logic [15:0] pkt_width,
	input wire logic [1:0] pkt_field,
	input wire logic img_active,
	input wire logic img_done,
	input wire logic [15:0] cur_plane0
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	sequence s_offer; pkt_valid && !pkt_ready; endsequence
	sequence s_take; pkt_valid && pkt_ready; endsequence
	sequence s_field_end; img_active && img_done && pkt_field != tpc_pkg::FIELD_PROGRESSIVE; endsequence
	property p_rvalid; reg_rd |=> reg_rvalid; endproperty
	property p_rquiet; !reg_rd |=> !reg_rvalid && $stable(reg_rdata); endproperty
	property p_rsvd; reg_rd && reg_addr inside {4'h2, 4'h3} |=> reg_rdata == 16'h0000; endproperty
	property p_hold; s_offer |=> pkt_valid && $stable(pkt_width) && $stable(pkt_field); endproperty
	property p_start; s_take |=> img_active && !pkt_valid; endproperty
	property p_excl; img_active |-> !pkt_valid; endproperty
	property p_done; img_active && img_done |=> !img_active; endproperty
	property p_snap; pkt_valid || img_active |=> $stable(cur_plane0); endproperty
	property p_field; s_field_end ##1 pkt_valid |-> pkt_field != $past(pkt_field) && pkt_field != 2'h0; endproperty
	a_rvalid: assert property (p_rvalid) else $error("read not answered");
	a_rquiet: assert property (p_rquiet) else $error("read data moved without a read");
	a_rsvd: assert property (p_rsvd) else $error("unused word read nonzero");
	a_hold: assert property (p_hold) else $error("packet changed before acceptance");
	a_start: assert property (p_start) else $error("image did not follow packet");
	a_excl: assert property (p_excl) else $error("packet offered during image");
	a_done: assert property (p_done) else $error("image did not end");
	a_snap: assert property (p_snap) else $error("snapshot moved in frame");
	a_field: assert property (p_field) else $error("second field kind wrong");
endmodule // tpc_regs_monitor

bind tpc_regs tpc_regs_monitor u_mon (.mclk, .sys_rst, .reg_addr, .reg_rd, .reg_rdata, .reg_rvalid,
	.pkt_valid, .pkt_ready, .pkt_width, .pkt_field, .img_active, .img_done, .cur_plane0);

// File: test/tpc_regs_test.sv
// Self-checking bench for the test pattern register bank.
// Inputs change on the falling edge; a sink model paces packets.
`timescale 1ns/10ps
module tpc_regs_test;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_wdata = 16'h0000;
	logic [3:0] lag = 4'h0;
	logic [15:0] reg_rdata, pkt_width, pkt_height, cur_pattern_index, cur_plane0, cur_plane1, cur_plane2;
	logic reg_rvalid, pkt_valid, pkt_ready, img_active, img_done, cur_border;
	logic [1:0] pkt_field;
	logic [15:0] r2_rdata, p2_width, p2_height;
	logic r2_rvalid, p2_valid, p2_ready, i2_active, i2_done;
	logic [1:0] p2_field;
	int num_errors = 0;
	int check_count = 0;
	always #25 mclk = ~mclk;
	tpc_regs dut (.mclk, .sys_rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid,
		.pkt_valid, .pkt_ready, .pkt_width, .pkt_height, .pkt_field, .img_active, .img_done,
		.cur_pattern_index, .cur_border, .cur_plane0, .cur_plane1, .cur_plane2);
	tpc_sink_model sink (.mclk, .pkt_valid, .img_active, .lag, .pkt_ready, .img_done);
	// Fixed copy: no run-time control and reduced readback, so it free-runs from reset
	tpc_regs #(.RUNTIME_CTRL(1'b0), .REDUCED_READBACK(1'b1)) dut2 (.mclk, .sys_rst, .reg_addr, .reg_wr, .reg_wdata,
		.reg_rd, .reg_rdata(r2_rdata), .reg_rvalid(r2_rvalid), .pkt_valid(p2_valid), .pkt_ready(p2_ready),
		.pkt_width(p2_width), .pkt_height(p2_height), .pkt_field(p2_field), .img_active(i2_active),
		.img_done(i2_done), .cur_pattern_index(), .cur_border(), .cur_plane0(), .cur_plane1(), .cur_plane2());
	tpc_sink_model sink2 (.mclk, .pkt_valid(p2_valid), .img_active(i2_active), .lag(4'h3), .pkt_ready(p2_ready),
		.img_done(i2_done));
	task automatic end_sim();
		if (num_errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
		@(negedge mclk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		chk({15'h0000, reg_rvalid}, 16'h0001);
		chk(reg_rdata, exp);
		@(negedge mclk);
	endtask
	// Bounded wait on pkt_valid (img=0) or img_active (img=1)
	task automatic wait_sig(input logic img, input logic lvl);
		int n;
		n = 0;
		while (((img ? img_active : pkt_valid) !== lvl) && n < 300) begin
			@(negedge mclk);
			n++;
		end
		if (n == 300)
			chk(16'h0001, 16'h0000);
	endtask
	task automatic quiet();
		int hits;
		hits = 0;
		repeat (20) begin
			@(negedge mclk);
			if (pkt_valid !== 1'b0)
				hits++;
		end
		chk(16'(hits), 16'h0000);
	endtask
	task automatic t_reset();
		logic [15:0] exp [11];
		exp = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, tpc_pkg::RESET_WIDTH, tpc_pkg::RESET_HEIGHT,
			16'h0000, 16'h0000, tpc_pkg::RESET_PLANE, tpc_pkg::RESET_PLANE, tpc_pkg::RESET_PLANE};
		for (int i = 0; i < 11; i++)
			rd(4'(i), exp[i]);
		quiet();
		for (int i = 1; i < 4; i++)
			wr(4'(i), 16'hFFFF);
		wr(4'hC, 16'hFFFF);
		for (int i = 1; i < 4; i++)
			rd(4'(i), 16'h0000);
		rd(4'hC, 16'h0000);
		wr(4'h0, 16'hFFFE);
		rd(4'h0, 16'h0002);
	endtask
	task automatic t_fixed();
		int n;
		n = 0;
		while (p2_valid !== 1'b1 && n < 300) begin
			@(negedge mclk);
			n++;
		end
		chk({15'h0000, p2_valid}, 16'h0001);
		chk(p2_width, tpc_pkg::RESET_WIDTH);
		chk(p2_height, tpc_pkg::RESET_HEIGHT);
		reg_addr = 4'h1;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		chk(r2_rdata, 16'h0001);
		@(negedge mclk);
		reg_addr = 4'h4;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		chk({15'h0000, r2_rvalid}, 16'h0001);
		chk(r2_rdata, 16'h0000);
		@(negedge mclk);
	endtask
	task automatic t_rw();
		for (int i = 4; i < 11; i++)
			wr(4'(i), 16'h0040 + 16'(i));
		for (int i = 4; i < 11; i++)
			rd(4'(i), 16'h0040 + 16'(i));
	endtask
	task automatic t_prog();
		lag = 4'h8;
		wr(4'h4, 16'h0020);
		wr(4'h5, 16'h0021);
		wr(4'h6, 16'h0000);
		wr(4'h7, 16'h0005);
		wr(4'h8, 16'h0055);
		wr(4'h0, 16'h0003);
		wait_sig(1'b0, 1'b1);
		chk(pkt_width, 16'h0020);
		chk(pkt_height, 16'h0021);
		chk({14'h0000, pkt_field}, 16'h0000);
		chk(cur_pattern_index, 16'h0005);
		chk(cur_plane0, 16'h0055);
		chk(cur_plane2, 16'h004A);
		chk({15'h0000, cur_border}, 16'h0001);
		rd(4'h1, 16'h0001);
		wr(4'h8, 16'h0077);
		wr(4'h0, 16'h0000);
		wait_sig(1'b1, 1'b1);
		chk(cur_plane0, 16'h0055);
		wait_sig(1'b1, 1'b0);
		rd(4'h1, 16'h0000);
		quiet();
	endtask
	task automatic t_intl(input logic [1:0] scan, input logic [1:0] f1, input logic [1:0] f2);
		lag = 4'h5 + 4'(scan);
		wr(4'h5, 16'h0064);
		wr(4'h6, {14'h0000, scan});
		wr(4'h9, 16'h0033);
		wr(4'h0, 16'h0001);
		wait_sig(1'b0, 1'b1);
		chk({14'h0000, pkt_field}, {14'h0000, f1});
		chk(pkt_height, 16'h0032);
		wr(4'h0, 16'h0000);
		wr(4'h9, 16'h0044);
		wait_sig(1'b1, 1'b1);
		wait_sig(1'b0, 1'b1);
		chk({14'h0000, pkt_field}, {14'h0000, f2});
		chk(pkt_width, 16'h0020);
		chk(pkt_height, 16'h0032);
		chk(cur_plane1, 16'h0033);
		wait_sig(1'b1, 1'b1);
		wait_sig(1'b1, 1'b0);
		quiet();
	endtask
	initial begin
		repeat (20) @(negedge mclk);
		sys_rst = 1'b0;
		t_reset();
		t_fixed();
		t_rw();
		t_prog();
		t_intl(tpc_pkg::SCAN_EVEN_FIRST, tpc_pkg::FIELD_EVEN, tpc_pkg::FIELD_ODD);
		t_intl(tpc_pkg::SCAN_ODD_FIRST, tpc_pkg::FIELD_ODD, tpc_pkg::FIELD_EVEN);
		end_sim();
	end
	// All scenarios need well under a thousand cycles
	initial begin
		repeat (20000) @(posedge mclk);
		num_errors++;
		end_sim();
	end
endmodule // tpc_regs_test
